// ### src/see_defines.svh
// Constants of the serial memory command engine: opcodes, special codes,
// array shape and timing figures.
// Assumes both ends include it by its bare name.
`ifndef SEE_DEFINES_SVH
`define SEE_DEFINES_SVH

`define SEE_AW 6
`define SEE_DW 16
`define SEE_WORDS 64
`define SEE_ONES 16'hFFFF

`define SEE_OP_SPECIAL 2'h0
`define SEE_OP_WRITE 2'h1
`define SEE_OP_READ 2'h2
`define SEE_OP_ERASE 2'h3
`define SEE_SP_DIS 2'h0
`define SEE_SP_WRITE_ALL 2'h1
`define SEE_SP_ERASE_ALL 2'h2
`define SEE_SP_EN 2'h3

`define SEE_HDR_BITS 8
`define SEE_FRAME_SHORT 9
`define SEE_FRAME_LONG 25

`define SEE_CLK_MHZ 100
`define SEE_T_ERASE_US 1000
`define SEE_T_WRITE_US 2000
`define SEE_T_ALL_US 15000
`define SEE_TCSL_NS 100
`define SEE_SCLK_HALF_NS 500
`define SEE_POLL_WAIT 16

`endif

// ### src/see_pkg.sv
// Types shared by both ends of the serial memory link.
// Assumes see_defines.svh carries the numeric constants.
package see_pkg;

  typedef enum logic [2:0] {
    see_cmd_read = 3'h0,
    see_cmd_write = 3'h1,
    see_cmd_erase = 3'h2,
    see_cmd_en = 3'h3,
    see_cmd_dis = 3'h4,
    see_cmd_erase_all = 3'h5,
    see_cmd_write_all = 3'h6
  } see_cmd_t;

  typedef enum logic [4:0] {
    ls_idle = 5'h01,
    ls_hdr = 5'h02,
    ls_data = 5'h04,
    ls_read = 5'h08,
    ls_done = 5'h10
  } see_lst_t;

  typedef enum logic [1:0] {
    cs_idle = 2'h1,
    cs_busy = 2'h2
  } see_cst_t;

  typedef enum logic [3:0] {
    hs_idle = 4'h1,
    hs_send = 4'h2,
    hs_desel = 4'h4,
    hs_poll = 4'h8
  } see_hst_t;

endpackage : see_pkg

// ### src/see_if.sv
// Serial link between host and memory device.
// The shared data wire is resolved here: data-out has a pull-up, and the
// device's data-in follows data-out whenever the host does not drive it.
`timescale 1ns/100ps
interface see_if;
  logic cs;
  logic sclk;
  logic di_out;
  logic di_oe;
  logic do_out;
  logic do_oe;
  logic do_line;
  logic di_line;

  assign do_line = do_oe ? do_out : 1'h1;
  assign di_line = di_oe ? di_out : do_line;

  modport dev (
    input cs,
    input sclk,
    input di_line,
    output do_out,
    output do_oe
  );

  modport host (
    output cs,
    output sclk,
    output di_out,
    output di_oe,
    input do_line
  );
endinterface : see_if

// ### src/see_dev.sv
// Memory device end: frame capture on the link clock, self-timed
// programming, enable latch and ready/busy signalling on data-out.
// Assumes the host drives chip select, serial clock and data-in, and that
// i_clk stands for the device's own timing oscillator.
`timescale 1ns/100ps
`include "see_defines.svh"
module see_dev #(
  parameter int unsigned ERASE_CYC = `SEE_T_ERASE_US * `SEE_CLK_MHZ,
  parameter int unsigned WRITE_CYC = `SEE_T_WRITE_US * `SEE_CLK_MHZ,
  parameter int unsigned ALL_CYC = `SEE_T_ALL_US * `SEE_CLK_MHZ,
  parameter int unsigned CSL_CYC =
    (`SEE_TCSL_NS * `SEE_CLK_MHZ + 999) / 1000
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  see_if.dev lnk,
  output logic o_busy,
  output logic o_prog_en
);
  import see_pkg::*;

  localparam int TW = $clog2(ALL_CYC + 1);
  localparam logic [3:0] CSL_N = 4'(CSL_CYC);

  generate
    if (ERASE_CYC < 1 || WRITE_CYC < ERASE_CYC || ALL_CYC < WRITE_CYC ||
        CSL_CYC < 1 || CSL_CYC > 15) begin : g_bad_param
      $error("see_dev: cycle counts out of range");
    end
  endgenerate

  // Nonvolatile array. Written only in the i_clk domain; the link side
  // reads it at the last address edge of a read, which is safe because
  // reads while a programming cycle runs are not meaningful anyway.
  logic [`SEE_DW-1:0] mem_q [0:`SEE_WORDS-1];

  //////////////////////////////////////////////////////////////////////////
  // Link clock domain: frame capture.

  see_lst_t st_q;
  logic [4:0] cnt_q;
  logic [14:0] sh_q;
  logic [`SEE_DW-1:0] rd_q;
  logic do_q;
  logic oe_q;
  logic tog_q;
  logic [7:0] cmd_q;
  logic [`SEE_DW-1:0] wd_q;

  wire di_w = lnk.di_line;
  wire [7:0] hdr_w = {sh_q[6:0], di_w};
  wire [1:0] op_w = hdr_w[7:6];
  wire [1:0] sp_w = hdr_w[5:4];
  wire hdr_end = (st_q == ls_hdr) && (cnt_q == 5'h07);
  wire dat_end = (st_q == ls_data) && (cnt_q == 5'h0F);
  wire is_rd = (op_w == `SEE_OP_READ);
  wire need_dat = (op_w == `SEE_OP_WRITE) ||
                  ((op_w == `SEE_OP_SPECIAL) && (sp_w == `SEE_SP_WRITE_ALL));
  wire fire = (hdr_end && !is_rd && !need_dat) || dat_end;
  wire rd_done = (st_q == ls_read) && (cnt_q == 5'h10);

  // Select low holds the capture logic in reset, so every frame starts
  // clean even if the clock never ran while the device was deselected.
  always_ff @(posedge lnk.sclk or negedge lnk.cs) begin
    if (!lnk.cs) begin
      st_q <= ls_idle;
      cnt_q <= 5'h00;
      sh_q <= 15'h0000;
      rd_q <= 16'h0000;
      do_q <= 1'h0;
      oe_q <= 1'h0;
    end else begin
      case (st_q)
        ls_idle: begin
          if (di_w) begin
            st_q <= ls_hdr;
            cnt_q <= 5'h00;
          end
        end
        ls_hdr: begin
          sh_q <= {sh_q[13:0], di_w};
          cnt_q <= cnt_q + 5'h01;
          if (hdr_end) begin
            cnt_q <= 5'h00;
            if (is_rd) begin
              rd_q <= mem_q[hdr_w[5:0]];
              do_q <= 1'h0;
              oe_q <= 1'h1;
              st_q <= ls_read;
            end else if (need_dat) begin
              st_q <= ls_data;
            end else begin
              st_q <= ls_done;
            end
          end
        end
        ls_data: begin
          sh_q <= {sh_q[13:0], di_w};
          cnt_q <= cnt_q + 5'h01;
          if (dat_end) begin
            st_q <= ls_done;
          end
        end
        ls_read: begin
          if (rd_done) begin
            oe_q <= 1'h0;
            st_q <= ls_done;
          end else begin
            do_q <= rd_q[`SEE_DW-1];
            rd_q <= {rd_q[`SEE_DW-2:0], 1'h0};
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ls_done: begin
          st_q <= ls_done;
        end
        default: begin
          st_q <= ls_idle;
        end
      endcase
    end
  end

  // The hand-off registers must survive the deselect that follows a
  // programming frame, so they are reset only by the system reset.
  always_ff @(posedge lnk.sclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tog_q <= 1'h0;
      cmd_q <= 8'h00;
      wd_q <= 16'h0000;
    end else begin
      if (hdr_end) begin
        cmd_q <= hdr_w;
      end
      if (dat_end) begin
        wd_q <= {sh_q, di_w};
      end
      if (fire) begin
        tog_q <= ~tog_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Own clock domain: execution, timer and status.

  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic cs_s1_q;
  logic cs_s2_q;
  see_cst_t cst_q;
  logic en_q;
  logic [TW-1:0] tmr_q;
  logic [7:0] job_q;
  logic [`SEE_DW-1:0] jwd_q;
  logic [3:0] clc_q;
  logic saw_q;
  logic stat_q;

  wire evt = tog_s2_q ^ tog_s3_q;
  wire c_spec = (cmd_q[7:6] == `SEE_OP_SPECIAL);
  wire c_en = c_spec && (cmd_q[5:4] == `SEE_SP_EN);
  wire c_dis = c_spec && (cmd_q[5:4] == `SEE_SP_DIS);
  wire c_erase_all = c_spec && (cmd_q[5:4] == `SEE_SP_ERASE_ALL);
  wire c_write_all = c_spec && (cmd_q[5:4] == `SEE_SP_WRITE_ALL);
  wire c_write = (cmd_q[7:6] == `SEE_OP_WRITE);
  wire c_erase = (cmd_q[7:6] == `SEE_OP_ERASE);
  wire c_prog = c_write || c_erase || c_erase_all || c_write_all;
  wire idle = (cst_q == cs_idle);
  wire busy = (cst_q == cs_busy);
  wire start = evt && c_prog && en_q && idle;
  wire fin = busy && (tmr_q == '0);
  wire [TW-1:0] load = c_write ? TW'(WRITE_CYC - 1) :
                       c_erase ? TW'(ERASE_CYC - 1) : TW'(ALL_CYC - 1);
  wire j_spec = (job_q[7:6] == `SEE_OP_SPECIAL);
  wire j_write = (job_q[7:6] == `SEE_OP_WRITE);
  wire j_erase = (job_q[7:6] == `SEE_OP_ERASE);
  wire j_erase_all = j_spec && (job_q[5:4] == `SEE_SP_ERASE_ALL);
  wire j_write_all = j_spec && (job_q[5:4] == `SEE_SP_WRITE_ALL);
  wire csl_met = (clc_q == CSL_N);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tog_s1_q <= 1'h0;
      tog_s2_q <= 1'h0;
      tog_s3_q <= 1'h0;
      cs_s1_q <= 1'h0;
      cs_s2_q <= 1'h0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      cs_s1_q <= lnk.cs;
      cs_s2_q <= cs_s1_q;
    end
  end

  // Commands that arrive while a cycle runs are dropped.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      en_q <= 1'h0;
    end else if (evt && idle && c_en) begin
      en_q <= 1'h1;
    end else if (evt && idle && c_dis) begin
      en_q <= 1'h0;
    end
  end

  // The cycle runs on i_clk alone, so it completes whatever select does.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cst_q <= cs_idle;
      tmr_q <= '0;
      job_q <= 8'h00;
      jwd_q <= 16'h0000;
    end else begin
      case (cst_q)
        cs_idle: begin
          if (start) begin
            cst_q <= cs_busy;
            tmr_q <= load;
            job_q <= cmd_q;
            jwd_q <= wd_q;
          end
        end
        cs_busy: begin
          if (fin) begin
            cst_q <= cs_idle;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        default: begin
          cst_q <= cs_idle;
        end
      endcase
    end
  end

  // Write-all only clears bits; a single write stores jwd_q as given and can raise a cell.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      for (int i = 0; i < `SEE_WORDS; i++) begin
        mem_q[i] <= `SEE_ONES;
      end
    end else if (fin) begin
      if (j_erase) begin
        mem_q[job_q[5:0]] <= `SEE_ONES;
      end else if (j_write) begin
        mem_q[job_q[5:0]] <= jwd_q;
      end else if (j_erase_all) begin
        for (int i = 0; i < `SEE_WORDS; i++) begin
          mem_q[i] <= `SEE_ONES;
        end
      end else if (j_write_all) begin
        for (int i = 0; i < `SEE_WORDS; i++) begin
          mem_q[i] <= mem_q[i] & jwd_q;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      clc_q <= 4'h0;
      saw_q <= 1'h0;
      stat_q <= 1'h0;
    end else begin
      if (cs_s2_q) begin
        clc_q <= 4'h0;
      end else if (!csl_met) begin
        clc_q <= clc_q + 4'h1;
      end
      if (start || fin) begin
        saw_q <= 1'h0;
      end else if (busy && csl_met) begin
        saw_q <= 1'h1;
      end
      if (!cs_s2_q) begin
        stat_q <= 1'h0;
      end else if (saw_q) begin
        stat_q <= 1'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins and user outputs. Select gates the enable directly so the pin
  // releases at once when select falls, with no clock needed.

  assign lnk.do_out = stat_q ? ~busy : do_q;
  assign lnk.do_oe = lnk.cs & (stat_q | oe_q);
  assign o_busy = busy;
  assign o_prog_en = en_q;

endmodule : see_dev

// ### src/see_host.sv
// Host end: turns one user command into a serial frame, reads back data,
// and polls ready/busy after programming commands.
// Assumes a single i_clk; the serial clock is divided from it.
`timescale 1ns/100ps
`include "see_defines.svh"
module see_host #(
  parameter int unsigned HALF_CYC =
    (`SEE_SCLK_HALF_NS * `SEE_CLK_MHZ + 999) / 1000,
  parameter int unsigned CSL_CYC =
    2 * ((`SEE_TCSL_NS * `SEE_CLK_MHZ + 999) / 1000),
  parameter int unsigned POLL_CYC = `SEE_POLL_WAIT
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire see_pkg::see_cmd_t i_cmd,
  input wire logic [`SEE_AW-1:0] i_addr,
  input wire logic [`SEE_DW-1:0] i_wdata,
  output logic o_ready,
  output logic o_done,
  output logic [`SEE_DW-1:0] o_rdata,
  see_if.host lnk
);
  import see_pkg::*;

  localparam logic [7:0] HALF_N = 8'(HALF_CYC);
  localparam logic [7:0] CSL_N = 8'(CSL_CYC);
  localparam logic [7:0] POLL_N = 8'(POLL_CYC);

  generate
    if (HALF_CYC < 4 || HALF_CYC > 255 || CSL_CYC < 1 || CSL_CYC > 255 ||
        POLL_CYC < 4 || POLL_CYC > 255) begin : g_bad_param
      $error("see_host: cycle counts out of range");
    end
  endgenerate

  see_hst_t hs_q;
  logic [7:0] div_q;
  logic [7:0] wt_q;
  logic sclk_q;
  logic cs_q;
  logic dioe_q;
  logic rd_q;
  logic prog_q;
  logic done_q;
  logic gap_q;
  logic [4:0] bit_q;
  logic [4:0] nb_q;
  logic [24:0] sh_q;
  logic [`SEE_DW-1:0] rdata_q;
  logic do_s1_q;
  logic do_s2_q;

  //////////////////////////////////////////////////////////////////////////
  // Frame building.

  wire c_read = (i_cmd == see_cmd_read);
  wire c_write = (i_cmd == see_cmd_write);
  wire c_erase = (i_cmd == see_cmd_erase);
  wire c_en = (i_cmd == see_cmd_en);
  wire c_erase_all = (i_cmd == see_cmd_erase_all);
  wire c_write_all = (i_cmd == see_cmd_write_all);
  wire [1:0] op_w = c_read ? `SEE_OP_READ : c_write ? `SEE_OP_WRITE :
                    c_erase ? `SEE_OP_ERASE : `SEE_OP_SPECIAL;
  wire [1:0] sp_w = c_en ? `SEE_SP_EN : c_erase_all ? `SEE_SP_ERASE_ALL :
                    c_write_all ? `SEE_SP_WRITE_ALL : `SEE_SP_DIS;
  wire [5:0] ad_w = (c_read || c_write || c_erase) ? i_addr : {sp_w, 4'h0};
  wire long_w = c_read || c_write || c_write_all;
  wire prog_w = c_write || c_erase || c_erase_all || c_write_all;
  wire half_end = (div_q == HALF_N - 8'h01);
  wire fall = (hs_q == hs_send) && sclk_q && half_end;
  wire last = fall && (bit_q == nb_q - 5'h01);

  //////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      do_s1_q <= 1'h1;
      do_s2_q <= 1'h1;
    end else begin
      do_s1_q <= lnk.do_line;
      do_s2_q <= do_s1_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      hs_q <= hs_idle;
      div_q <= 8'h00;
      wt_q <= 8'h00;
      sclk_q <= 1'h0;
      cs_q <= 1'h0;
      dioe_q <= 1'h0;
      rd_q <= 1'h0;
      prog_q <= 1'h0;
      done_q <= 1'h0;
      gap_q <= 1'h0;
      bit_q <= 5'h00;
      nb_q <= 5'h00;
      sh_q <= 25'h0000000;
      rdata_q <= 16'h0000;
    end else begin
      done_q <= 1'h0;
      case (hs_q)
        hs_idle: begin
          if (i_req) begin
            sh_q <= {1'h1, op_w, ad_w, i_wdata};
            nb_q <= long_w ? 5'(`SEE_FRAME_LONG) : 5'(`SEE_FRAME_SHORT);
            rd_q <= c_read;
            prog_q <= prog_w;
            cs_q <= 1'h1;
            dioe_q <= 1'h1;
            bit_q <= 5'h00;
            div_q <= 8'h00;
            sclk_q <= 1'h0;
            hs_q <= hs_send;
          end
        end
        hs_send: begin
          div_q <= half_end ? 8'h00 : div_q + 8'h01;
          if (half_end) begin
            sclk_q <= ~sclk_q;
          end
          if (fall) begin
            sh_q <= {sh_q[23:0], 1'h0};
            bit_q <= bit_q + 5'h01;
            if (rd_q && bit_q == 5'(`SEE_HDR_BITS)) begin
              dioe_q <= 1'h0;
            end
            if (rd_q && bit_q > 5'(`SEE_HDR_BITS)) begin
              rdata_q <= {rdata_q[`SEE_DW-2:0], do_s2_q};
            end
            if (last) begin
              cs_q <= 1'h0;
              dioe_q <= 1'h0;
              wt_q <= 8'h00;
              gap_q <= ~prog_q;
              hs_q <= hs_desel;
            end
          end
        end
        hs_desel: begin
          wt_q <= wt_q + 8'h01;
          if (wt_q == CSL_N) begin
            wt_q <= 8'h00;
            if (gap_q) begin
              done_q <= 1'h1;
              hs_q <= hs_idle;
            end else begin
              cs_q <= 1'h1;
              hs_q <= hs_poll;
            end
          end
        end
        hs_poll: begin
          if (wt_q != POLL_N) begin
            wt_q <= wt_q + 8'h01;
          end else if (do_s2_q) begin
            cs_q <= 1'h0;
            wt_q <= 8'h00;
            gap_q <= 1'h1;
            hs_q <= hs_desel;
          end
        end
        default: begin
          hs_q <= hs_idle;
        end
      endcase
    end
  end

  assign lnk.cs = cs_q;
  assign lnk.sclk = sclk_q;
  assign lnk.di_out = sh_q[24];
  assign lnk.di_oe = dioe_q;
  assign o_ready = (hs_q == hs_idle);
  assign o_done = done_q;
  assign o_rdata = rdata_q;

endmodule : see_host

// ### tb/see_monitor.sv
// Checker for the serial link between host and memory device.
// Assumes it watches the interface signals, sampled on the host clock, and
// the device's busy flag, which comes from the other clock domain.
`timescale 1ns/100ps
module see_monitor (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic cs,
  input wire logic sclk,
  input wire logic di_line,
  input wire logic di_oe,
  input wire logic do_oe,
  input wire logic do_line,
  input wire logic i_busy
);
  logic sclk_q;
  logic [4:0] cnt_q;
  logic [8:0] hdr_q;
  logic rise;
  logic rd;
  logic long_frm;

  // The header decode is only meaningful once all nine bits are in.
  assign rise = sclk & ~sclk_q;
  assign rd = (hdr_q[7:6] == 2'h2);
  assign long_frm = rd | (hdr_q[7:6] == 2'h1) | (hdr_q[7:4] == 4'h1);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) sclk_q <= 1'h0;
    else sclk_q <= sclk;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn || !cs) cnt_q <= 5'h00;
    else if (rise && cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn || !cs) hdr_q <= 9'h000;
    else if (rise && cnt_q < 5'h09) hdr_q <= {hdr_q[7:0], di_line};
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_start;
    cs && rise && cnt_q == 5'h00 |-> di_line;
  endproperty
  a_start: assert property (p_start)
    else $error("first clock rise of a frame carries no start bit");

  property p_frame_len;
    $fell(cs) && cnt_q != 5'h00 |-> cnt_q == (long_frm ? 5'h19 : 5'h09);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length does not match its command");

  property p_dummy;
    rd && cnt_q == 5'h09 && $past(cnt_q) == 5'h08 |-> do_oe && !do_line;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("read does not start with a driven zero");

  property p_rd_oe;
    cs && rd && cnt_q >= 5'h09 |-> do_oe;
  endproperty
  a_rd_oe: assert property (p_rd_oe)
    else $error("read output released while select is high");

  property p_rd_chg;
    cs && rd && cnt_q >= 5'h09 && $past(do_oe) && $changed(do_line) |-> rise;
  endproperty
  a_rd_chg: assert property (p_rd_chg)
    else $error("read output changed away from a clock rise");

  property p_quiet;
    cs && cnt_q != 5'h00 && (cnt_q < 5'h08 || (!rd && cnt_q >= 5'h09))
      |-> !do_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("data-out driven inside a frame that gives no data");

  property p_cs_low;
    !cs |-> !do_oe;
  endproperty
  a_cs_low: assert property (p_cs_low)
    else $error("data-out driven while deselected");

  property p_release;
    cs && do_oe && cnt_q == 5'h00 |-> !di_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("host drives the shared wire during status");

  property p_stat_busy;
    cs && do_oe && cnt_q == 5'h00 && !do_line |-> i_busy || $past(i_busy, 2);
  endproperty
  a_stat_busy: assert property (p_stat_busy)
    else $error("status shows busy with no cycle running");

  property p_stat_rdy;
    cs && do_oe && cnt_q == 5'h00 && do_line |-> !i_busy || !$past(i_busy, 2);
  endproperty
  a_stat_rdy: assert property (p_stat_rdy)
    else $error("status shows ready while a cycle runs");
endmodule : see_monitor

// ### tb/testbench.sv
// Self-checking bench: host and device joined by the link interface.
// Assumes the host end is driven through its command port; the device
// runs on its own unrelated clock with shortened programming times.
`timescale 1ns/100ps
`include "see_defines.svh"
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin \
  err_count++; $display("[ERR] %0t act=%0h exp=%0h", $time, act, exp); \
  end end
module testbench;
  import see_pkg::*;
  localparam int ER = 20;
  localparam int WR = 40;
  localparam int AL = 60;
  logic i_clk;
  logic dev_clk;
  logic i_rstn;
  logic dev_rstn;
  logic i_req;
  see_cmd_t i_cmd;
  logic [`SEE_AW-1:0] i_addr;
  logic [`SEE_DW-1:0] i_wdata;
  logic o_ready;
  logic o_done;
  logic [`SEE_DW-1:0] o_rdata;
  logic o_busy;
  logic o_prog_en;
  int err_count;
  int cmp_count;
  int bcnt;
  int blen;

  see_if lnk ();

  see_dev #(.ERASE_CYC(ER), .WRITE_CYC(WR), .ALL_CYC(AL), .CSL_CYC(5))
    i_see_dev (.i_clk(dev_clk), .i_rstn(dev_rstn), .lnk(lnk.dev),
    .o_busy(o_busy), .o_prog_en(o_prog_en));

  see_host #(.HALF_CYC(5), .CSL_CYC(20), .POLL_CYC(16)) i_see_host (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_cmd(i_cmd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
    .o_done(o_done), .o_rdata(o_rdata), .lnk(lnk.host));

  see_monitor i_see_monitor (.i_clk(i_clk), .i_rstn(i_rstn), .cs(lnk.cs),
    .sclk(lnk.sclk), .di_line(lnk.di_line), .di_oe(lnk.di_oe),
    .do_oe(lnk.do_oe), .do_line(lnk.do_line), .i_busy(o_busy));

  ////////////////////////////////////////////////////////////////////////////
  // The 15 ns device clock never shares a rising edge with the 10 ns host clock.
  always #5 i_clk = ~i_clk;
  always #7.5 dev_clk = ~dev_clk;

  // Length of the last busy run, in device clock cycles.
  always @(posedge dev_clk) begin
    if (o_busy === 1'b1) begin
      bcnt <= bcnt + 1;
    end else if (bcnt != 0) begin
      blen <= bcnt;
      bcnt <= 0;
    end
  end

  task automatic end_sim;
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Waits for ready (sel 0) or done (sel 1) with a bounded count.
  task automatic wait_hi(input bit sel);
    int n;
    n = 0;
    while ((sel ? o_done : o_ready) !== 1'b1) begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > 5000) begin
        `CHK(1'b0, 1'b1)
        end_sim();
      end
    end
  endtask : wait_hi

  task automatic run(input see_cmd_t c, input logic [`SEE_AW-1:0] a,
                     input logic [`SEE_DW-1:0] d);
    wait_hi(1'b0);
    blen = 0;
    i_cmd = c;
    i_addr = a;
    i_wdata = d;
    i_req = 1'b1;
    @(posedge i_clk);
    #1;
    i_req = 1'b0;
    wait_hi(1'b1);
  endtask : run

  task automatic rd(input logic [`SEE_AW-1:0] a,
                    input logic [`SEE_DW-1:0] exp);
    run(see_cmd_read, a, 16'h0000);
    `CHK(o_rdata, exp)
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    dev_clk = 1'b0;
    i_rstn = 1'b0;
    dev_rstn = 1'b0;
    i_req = 1'b0;
    i_cmd = see_cmd_read;
    i_addr = 6'h00;
    i_wdata = 16'h0000;
    err_count = 0;
    cmp_count = 0;
    bcnt = 0;
    blen = 0;
    fork
      begin
        repeat (2) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
      end
      begin
        repeat (6) @(posedge dev_clk);
        #1;
        dev_rstn = 1'b1;
      end
    join
    @(posedge i_clk);
    #1;
    `CHK(o_prog_en, 1'b0)
    // Programming before the enable command must leave the word erased.
    run(see_cmd_write, 6'h05, 16'h1234);
    `CHK(blen, 0)
    `CHK(o_ready, 1'b1)
    rd(6'h05, 16'hFFFF);
    run(see_cmd_en, 6'h00, 16'h0000);
    `CHK(o_prog_en, 1'b1)
    run(see_cmd_write, 6'h05, 16'h1234);
    `CHK(blen, WR)
    rd(6'h05, 16'h1234);
    run(see_cmd_write, 6'h3F, 16'hA5C3);
    `CHK(blen, WR)
    rd(6'h3F, 16'hA5C3);
    rd(6'h05, 16'h1234);
    run(see_cmd_erase, 6'h05, 16'h0000);
    `CHK(blen, ER)
    rd(6'h05, 16'hFFFF);
    rd(6'h3F, 16'hA5C3);
    run(see_cmd_erase_all, 6'h00, 16'h0000);
    `CHK(blen, AL)
    rd(6'h3F, 16'hFFFF);
    run(see_cmd_write_all, 6'h00, 16'h5A5A);
    `CHK(blen, AL)
    rd(6'h00, 16'h5A5A);
    // A second fill without an erase can only clear further bits.
    run(see_cmd_write_all, 6'h00, 16'h0F0F);
    rd(6'h3F, 16'h0A0A);
    run(see_cmd_dis, 6'h00, 16'h0000);
    `CHK(o_prog_en, 1'b0)
    run(see_cmd_erase, 6'h3F, 16'h0000);
    `CHK(blen, 0)
    run(see_cmd_erase_all, 6'h00, 16'h0000);
    `CHK(blen, 0)
    rd(6'h3F, 16'h0A0A);
    end_sim();
  end
endmodule : testbench
